// ### pkg/psrb_regs.svh
// Register codes, field layout, command codes and reset values of the sensor register bank.
`ifndef PSRB_REGS_SVH
`define PSRB_REGS_SVH

// Register codes on the 4-bit address field.
`define PSRB_ADDR_CLAMP_LO 4'h1
`define PSRB_ADDR_CLAMP_HI 4'h2
`define PSRB_ADDR_QUIESC 4'h3
`define PSRB_ADDR_GAIN 4'h4
`define PSRB_ADDR_CONFIG 4'h5
`define PSRB_ADDR_LOCK 4'h6
`define PSRB_ADDR_IN_CONV 4'h7
`define PSRB_ADDR_GP_SET 4'h8
`define PSRB_ADDR_OUT_CONV 4'h9
`define PSRB_ADDR_TEMP 4'hb
`define PSRB_ADDR_GP_FIRST 4'hc
`define PSRB_ADDR_SHUTDOWN 4'hf

// Data widths of each register.
`define PSRB_DATA_W 14
`define PSRB_W_CLAMP_LO 8
`define PSRB_W_CLAMP_HI 9
`define PSRB_W_QUIESC 11
`define PSRB_W_GAIN 14
`define PSRB_W_CONFIG 10
`define PSRB_W_LOCK 2
`define PSRB_W_TEMP 10
`define PSRB_W_GP 13
`define PSRB_GP_COUNT 4

// Temperature compensation fields and operating config fields.
`define PSRB_TEMP_SQ_LSB 0
`define PSRB_TEMP_SQ_MSB 2
`define PSRB_TEMP_LIN_LSB 3
`define PSRB_TEMP_LIN_MSB 7
`define PSRB_TEMP_GRP_LSB 8
`define PSRB_TEMP_GRP_MSB 9
`define PSRB_CFG_RANGE_HI 9
`define PSRB_CFG_STYLE_LSB 5
`define PSRB_CFG_STYLE_MSB 8
`define PSRB_CFG_FILT_LSB 3
`define PSRB_CFG_FILT_MSB 4
`define PSRB_CFG_RANGE_LSB 1
`define PSRB_CFG_RANGE_MSB 2

// Command codes on the 3-bit command field.
`define PSRB_CMD_READ 3'h2
`define PSRB_CMD_WRITE 3'h3
`define PSRB_CMD_BURN 3'h4
`define PSRB_CMD_ERASE 3'h5

// Shutdown key and reset value of the working copy.
`define PSRB_SHUTDOWN_KEY 14'h080F
`define PSRB_RESET_DATA 14'h0000
`endif

// ### pkg/psrb_pkg.sv
// Types shared by the sensor register bank.
`include "psrb_regs.svh"
package psrb_pkg;
  // Calibration set held in working copy and in storage.
  typedef struct packed {
    logic [`PSRB_W_CLAMP_LO-1:0] clamp_lo;
    logic [`PSRB_W_CLAMP_HI-1:0] clamp_hi;
    logic [`PSRB_W_QUIESC-1:0] quiescent_offset;
    logic [`PSRB_W_GAIN-1:0] gain;
    logic [`PSRB_W_CONFIG-1:0] operating_config;
    logic [`PSRB_W_LOCK-1:0] lock_control;
    logic [`PSRB_W_TEMP-1:0] temp_compensation;
    logic [`PSRB_GP_COUNT-1:0][`PSRB_W_GP-1:0] gp;
  } psrb_cal_t;
  // One decoded telegram from the programmer.
  typedef struct packed {
    logic valid;
    logic [2:0] cmd;
    logic [3:0] addr;
    logic [`PSRB_DATA_W-1:0] data;
  } psrb_req_t;
  // Answer to the programmer: acknowledge plus read data.
  typedef struct packed {
    logic valid;
    logic is_read;
    logic [`PSRB_DATA_W-1:0] data;
  } psrb_rsp_t;
  // Whole state of the bank.
  typedef struct packed {
    psrb_cal_t ram;
    psrb_cal_t nv;
    logic [1:0] gp_idx;
    logic shut;
    logic act_s1;
    logic act_s2;
    logic act_s3;
    psrb_rsp_t rsp;
  } psrb_state_t;
endpackage

// ### src/psrb_bank.sv
// Register bank of the programmable linear sensor, driven by decoded telegrams.
`include "psrb_regs.svh"
module psrb_bank import psrb_pkg::*; (
  // Clock and synchronous reset.
  input wire logic clock,
  input wire logic resetn,
  // Decoded telegram and its answer.
  input wire psrb_req_t req,
  output psrb_rsp_t rsp,
  // Converter readouts from the signal path.
  input wire logic [`PSRB_DATA_W-1:0] in_conv_value,
  input wire logic [`PSRB_DATA_W-1:0] out_conv_value,
  // Activate pulse sensed on the output pin.
  input wire logic activate_pin,
  // Calibration towards the signal path and power state.
  output psrb_cal_t cal,
  output psrb_cal_t stored_cal,
  output logic shut_down
);
  psrb_state_t s_reg; // Registered state.
  psrb_state_t s_next; // Next state.
  logic act_rise; // Synchronised rising edge of the activate pin.
  logic taken; // A telegram is accepted this cycle.
  logic [`PSRB_DATA_W-1:0] rd; // Left-justified read data.
  logic [`PSRB_DATA_W-1:0] rev; // Bit-reversed output converter value.

  // Reverse the converter bits, since the reply shifts them out LSB first.
  always_comb begin
    for (int i = 0; i < `PSRB_DATA_W; i++) begin
      rev[i] = out_conv_value[`PSRB_DATA_W-1-i];
    end
  end

  // Reply data: narrow registers sit at the front of the 14-bit field.
  always_comb begin
    rd = `PSRB_RESET_DATA;
    case (req.addr)
      `PSRB_ADDR_CLAMP_LO: rd = {s_reg.ram.clamp_lo, 6'h00};
      `PSRB_ADDR_CLAMP_HI: rd = {s_reg.ram.clamp_hi, 5'h00};
      `PSRB_ADDR_QUIESC: rd = {s_reg.ram.quiescent_offset, 3'h0};
      `PSRB_ADDR_GAIN: rd = s_reg.ram.gain;
      `PSRB_ADDR_CONFIG: rd = {s_reg.ram.operating_config, 4'h0};
      `PSRB_ADDR_LOCK: rd = {s_reg.ram.lock_control, 12'h000};
      `PSRB_ADDR_IN_CONV: rd = in_conv_value;
      `PSRB_ADDR_OUT_CONV: rd = rev;
      `PSRB_ADDR_TEMP: rd = {s_reg.ram.temp_compensation, 4'h0};
      `PSRB_ADDR_GP_FIRST: rd = {s_reg.ram.gp[0], 1'b0};
      `PSRB_ADDR_GP_SET: rd = {s_reg.ram.gp[s_reg.gp_idx], 1'b0};
      default: rd = `PSRB_RESET_DATA;
    endcase
  end

  // Only the second and third stages of the pin synchroniser feed logic.
  assign act_rise = s_reg.act_s2 & ~s_reg.act_s3;
  // A shut-down sensor ignores every telegram until woken.
  assign taken = req.valid & ~s_reg.shut;

  // Next-state logic for the whole bank.
  always_comb begin
    s_next = s_reg;
    s_next.act_s1 = activate_pin;
    s_next.act_s2 = s_reg.act_s1;
    s_next.act_s3 = s_reg.act_s2;
    s_next.rsp = '0;
    // Wake on an activate edge; a telegram that arrives while shut is not taken.
    if (act_rise) begin
      s_next.shut = 1'b0;
    end
    if (taken) begin
      case (req.cmd)
        `PSRB_CMD_READ: begin
          s_next.rsp.valid = 1'b1;
          s_next.rsp.is_read = 1'b1;
          s_next.rsp.data = rd;
          // The set is walked in order; the first member restarts the walk.
          if (req.addr == `PSRB_ADDR_GP_FIRST) begin
            s_next.gp_idx = 2'h1;
          end else if (req.addr == `PSRB_ADDR_GP_SET && s_reg.gp_idx != 2'h3) begin
            s_next.gp_idx = s_reg.gp_idx + 2'h1;
          end
        end
        `PSRB_CMD_WRITE: begin
          s_next.rsp.valid = 1'b1;
          // Trailing data bits carry the value; read-only codes fall through.
          case (req.addr)
            `PSRB_ADDR_CLAMP_LO: s_next.ram.clamp_lo = req.data[7:0];
            `PSRB_ADDR_CLAMP_HI: s_next.ram.clamp_hi = req.data[8:0];
            `PSRB_ADDR_QUIESC: s_next.ram.quiescent_offset = req.data[10:0];
            `PSRB_ADDR_GAIN: s_next.ram.gain = req.data;
            `PSRB_ADDR_CONFIG: s_next.ram.operating_config = req.data[9:0];
            `PSRB_ADDR_LOCK: s_next.ram.lock_control = req.data[1:0];
            `PSRB_ADDR_TEMP: s_next.ram.temp_compensation = req.data[9:0];
            `PSRB_ADDR_GP_FIRST: begin
              s_next.ram.gp[0] = req.data[12:0];
              s_next.gp_idx = 2'h1;
            end
            `PSRB_ADDR_GP_SET: begin
              s_next.ram.gp[s_reg.gp_idx] = req.data[12:0];
              if (s_reg.gp_idx != 2'h3) begin
                s_next.gp_idx = s_reg.gp_idx + 2'h1;
              end
            end
            `PSRB_ADDR_SHUTDOWN: begin
              // Any other value leaves the sensor running.
              if (req.data == `PSRB_SHUTDOWN_KEY) begin
                s_next.shut = 1'b1;
              end
            end
            default: begin
              // Readouts and unused codes keep their contents.
              s_next.ram = s_reg.ram;
            end
          endcase
        end
        `PSRB_CMD_ERASE: begin
          // Storage commands act on everything at once, only with address zero.
          if (req.addr == 4'h0) begin
            s_next.nv = '0;
            s_next.rsp.valid = 1'b1;
          end
        end
        `PSRB_CMD_BURN: begin
          if (req.addr == 4'h0) begin
            s_next.nv = s_reg.ram;
            s_next.rsp.valid = 1'b1;
          end
        end
        default: begin
          // Unknown commands get no acknowledge.
          s_next.rsp = '0;
        end
      endcase
    end
    // Power-up clears the bank and the storage model alike.
    if (!resetn) begin
      s_next = '0;
    end
  end

  // State register.
  always_ff @(posedge clock) begin
    s_reg <= s_next;
  end

  // Outputs are all taken straight from flip-flops.
  assign rsp = s_reg.rsp;
  assign cal = s_reg.ram;
  assign stored_cal = s_reg.nv;
  assign shut_down = s_reg.shut;

  // Helper sequences for the assertions.
  sequence seq_key_write;
    req.valid && !shut_down && req.cmd == `PSRB_CMD_WRITE
      && req.addr == `PSRB_ADDR_SHUTDOWN && req.data == `PSRB_SHUTDOWN_KEY;
  endsequence
  sequence seq_wake;
    shut_down && act_rise;
  endsequence

  a_shutdown_key: assert property (@(posedge clock) disable iff (!resetn)
    seq_key_write |=> shut_down && rsp.valid)
    else $error("Shutdown key did not shut the sensor down.");
  a_shutdown_other: assert property (@(posedge clock) disable iff (!resetn)
    $rose(shut_down) |-> $past(req.valid) && $past(req.data) == `PSRB_SHUTDOWN_KEY)
    else $error("Shutdown happened without the key.");
  a_wake_pulse: assert property (@(posedge clock) disable iff (!resetn)
    seq_wake |=> !shut_down)
    else $error("Activate pulse did not wake the sensor.");
  a_shut_silent: assert property (@(posedge clock) disable iff (!resetn)
    shut_down && !act_rise |=> !rsp.valid [*2])
    else $error("Shut-down sensor answered a telegram.");
  a_ro_kept: assert property (@(posedge clock) disable iff (!resetn)
    req.valid && req.cmd == `PSRB_CMD_WRITE && (req.addr == `PSRB_ADDR_IN_CONV
      || req.addr == `PSRB_ADDR_OUT_CONV) |=> $stable(cal))
    else $error("Write to a read-only register changed the bank.");
  a_clamp_write: assert property (@(posedge clock) disable iff (!resetn)
    taken && req.cmd == `PSRB_CMD_WRITE && req.addr == `PSRB_ADDR_CLAMP_LO
      |=> cal.clamp_lo == $past(req.data[7:0]))
    else $error("Low clamp did not take the trailing bits.");
  a_gain_read: assert property (@(posedge clock) disable iff (!resetn)
    taken && req.cmd == `PSRB_CMD_READ && req.addr == `PSRB_ADDR_GAIN
      |=> rsp.is_read && rsp.data == $past(cal.gain))
    else $error("Gain readback mismatch.");
  a_out_reverse: assert property (@(posedge clock) disable iff (!resetn)
    taken && req.cmd == `PSRB_CMD_READ && req.addr == `PSRB_ADDR_OUT_CONV
      |=> rsp.data[0] == $past(out_conv_value[13]) && rsp.data[13] == $past(out_conv_value[0]))
    else $error("Output converter readout not reversed.");
  a_burn_copy: assert property (@(posedge clock) disable iff (!resetn)
    taken && req.cmd == `PSRB_CMD_BURN && req.addr == 4'h0 |=> stored_cal == $past(cal))
    else $error("Burn did not store the working copy.");
  a_temp_align: assert property (@(posedge clock) disable iff (!resetn)
    taken && req.cmd == `PSRB_CMD_READ && req.addr == `PSRB_ADDR_TEMP
      |=> rsp.data[3:0] == 4'h0 && rsp.data[13:4] == $past(cal.temp_compensation))
    else $error("Temperature compensation reply misaligned.");
endmodule // psrb_bank

// ### sim/psrb_prog_model.sv
// Programmer model that issues decoded telegrams to the sensor bank.
module psrb_prog_model import psrb_pkg::*; (
  // Clock.
  input wire logic clock,
  // Telegram towards the bank and its answer.
  output psrb_req_t req,
  input wire psrb_rsp_t rsp
);
  timeunit 1ns;
  timeprecision 1ns;
  logic ack; // Acknowledge seen on the last telegram.
  logic [13:0] rdat; // Read data of the last telegram.
  initial req = '0;
  // One telegram for one edge. Idle fields show inverted values, so stale data never matches.
  task automatic xfer(input logic [2:0] c, input logic [3:0] a, input logic [13:0] d);
    @(posedge clock);
    req <= '{1'b1, c, a, d};
    @(posedge clock);
    req <= '{1'b0, ~c, ~a, ~d};
    #1;
    ack = rsp.valid;
    rdat = rsp.data;
  endtask
  // Writes the whole set, first register first, with no store in between.
  task automatic gp_write(input logic [3:0][12:0] v);
    for (int i = 0; i < 4; i++) begin
      xfer(3'h3, (i == 0) ? 4'hc : 4'h8, {1'b0, v[i]});
    end
  endtask
  // Reads the whole set in the same order; values stay left-justified.
  task automatic gp_read(output logic [3:0][13:0] v);
    for (int i = 0; i < 4; i++) begin
      xfer(3'h2, (i == 0) ? 4'hc : 4'h8, 14'h0000);
      v[i] = rdat;
    end
  endtask
  // Changes only the first register; the others are read and written back.
  task automatic gp_set_first(input logic [12:0] v0);
    logic [3:0][12:0] v;
    v[0] = v0;
    xfer(3'h2, 4'hc, 14'h0000);
    for (int i = 1; i < 4; i++) begin
      xfer(3'h2, 4'h8, 14'h0000);
      v[i] = rdat[13:1];
    end
    gp_write(v);
  endtask
  // Permanent store is erase then burn, both at address zero.
  task automatic store();
    xfer(3'h5, 4'h0, 14'h0000);
    xfer(3'h4, 4'h0, 14'h0000);
  endtask
endmodule // psrb_prog_model

// ### sim/psrb_bank_tb_top.sv
// Self-checking bench for the sensor register bank.
module psrb_bank_tb_top import psrb_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic [13:0] in_conv_value = 14'h0000;
  logic [13:0] out_conv_value = 14'h0000;
  logic activate_pin = 1'b0;
  psrb_req_t req;
  psrb_rsp_t rsp;
  psrb_cal_t cal, stored_cal, snap;
  logic shut_down;
  logic [13:0] rdat; // Read data of the last send.
  int error_cnt = 0;
  int num_checks = 0;
  // Read-write codes and their widths.
  logic [3:0] codes [7] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'hb};
  int widths [7] = '{8, 9, 11, 14, 10, 2, 10};
  initial forever #10 clock = ~clock;
  psrb_bank u_psrb_bank (.clock(clock), .resetn(resetn), .req(req), .rsp(rsp),
    .in_conv_value(in_conv_value), .out_conv_value(out_conv_value),
    .activate_pin(activate_pin), .cal(cal), .stored_cal(stored_cal), .shut_down(shut_down));
  psrb_prog_model u_psrb_prog_model (.clock(clock), .req(req), .rsp(rsp));
  // Compares one value and reports a mismatch at once.
  task automatic check(input logic [13:0] got, input logic [13:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One telegram, with the acknowledge compared against what is expected.
  task automatic send(input logic [2:0] c, input logic [3:0] a, input logic [13:0] d,
    input logic exp_ack);
    u_psrb_prog_model.xfer(c, a, d);
    rdat = u_psrb_prog_model.rdat;
    check(14'(u_psrb_prog_model.ack), 14'(exp_ack));
  endtask
  // Bit reversal worked out here, independent of the design.
  function automatic logic [13:0] rev(input logic [13:0] v);
    for (int i = 0; i < 14; i++) rev[i] = v[13 - i];
  endfunction
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Main sequence of tests.
  initial begin
    logic [3:0][13:0] gv;
    logic [3:0][12:0] wv;
    logic [13:0] d;
    repeat (8) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    #1;
    check(14'(|cal), 14'h0000);
    check(14'(|stored_cal), 14'h0000);
    // Boundary patterns: upper bits must be dropped on write, value left-justified on read.
    foreach (codes[i]) begin
      for (int p = 0; p < 2; p++) begin
        d = p ? 14'h2AAA : 14'h3FFF;
        send(3'h3, codes[i], d, 1'b1);
        send(3'h2, codes[i], 14'h0000, 1'b1);
        check(rdat, 14'(d & ((1 << widths[i]) - 1)) << (14 - widths[i]));
      end
    end
    check(cal.gain, 14'h2AAA);
    check(14'(cal.temp_compensation), 14'h02AA);
    $display("test registers done");
    @(posedge clock);
    in_conv_value <= 14'h2C35;
    out_conv_value <= 14'h0C01;
    snap = cal;
    send(3'h2, 4'h7, 14'h0000, 1'b1);
    check(rdat, 14'h2C35);
    send(3'h2, 4'h9, 14'h0000, 1'b1);
    check(rdat, rev(14'h0C01));
    send(3'h3, 4'h9, 14'h1234, 1'b1);
    send(3'h3, 4'h7, 14'h1234, 1'b1);
    send(3'h2, 4'h9, 14'h0000, 1'b1);
    check(rdat, rev(14'h0C01));
    check(14'(cal !== snap), 14'h0000);
    send(3'h7, 4'h1, 14'h0000, 1'b0);
    $display("test readouts done");
    wv = {13'h0AAA, 13'h1555, 13'h0F0F, 13'h1ABC};
    u_psrb_prog_model.gp_write(wv);
    u_psrb_prog_model.gp_read(gv);
    for (int i = 0; i < 4; i++) check(gv[i], {wv[i], 1'b0});
    u_psrb_prog_model.gp_set_first(13'h0123);
    u_psrb_prog_model.gp_read(gv);
    wv[0] = 13'h0123;
    for (int i = 0; i < 4; i++) check(gv[i], {wv[i], 1'b0});
    $display("test general purpose done");
    send(3'h5, 4'h1, 14'h0000, 1'b0);
    u_psrb_prog_model.store();
    check(14'(stored_cal !== cal), 14'h0000);
    send(3'h5, 4'h0, 14'h0000, 1'b1);
    check(14'(|stored_cal), 14'h0000);
    $display("test store done");
    send(3'h3, 4'hf, 14'h080E, 1'b1);
    check(14'(shut_down), 14'h0000);
    send(3'h3, 4'hf, 14'h080F, 1'b1);
    check(14'(shut_down), 14'h0001);
    send(3'h2, 4'h1, 14'h0000, 1'b0);
    activate_pin <= 1'b1;
    for (int n = 0; n < 8 && shut_down !== 1'b0; n++) begin
      @(posedge clock);
      #1;
    end
    if (shut_down !== 1'b0) begin
      error_cnt++;
      $display("unexpected at %0t: wake timed out", $time);
      print_verdict();
    end
    activate_pin <= 1'b0;
    send(3'h2, 4'h1, 14'h0000, 1'b1);
    check(rdat, 14'h2A80);
    send(3'h3, 4'hf, 14'h080F, 1'b1);
    @(posedge clock);
    resetn <= 1'b0;
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    #1;
    check(14'(shut_down), 14'h0000);
    $display("test shutdown done");
    print_verdict();
  end
endmodule // psrb_bank_tb_top
